// File: sfm_meter.sv
`timescale 1ns/10ps
// How it works
// [RL1] input pulses narrower than one clock period are dropped as noise.
// [RL2] the horizontal input is always watched and a found vertical pulse sets a present flag.
// [RL3] a control bit picks the separated pulse instead of the vertical input as source.
// [RL4] the separated pulse appears at least 10 us after its composite pulse began.
// [RL5] a 15-bit counter times 64 horizontal periods.
// [RL6] the upper 11 counter bits form the horizontal result, twice the period.
// [RL7] the horizontal latch loads per vertical period if vertical is present, else each result.
// [RL8] a 14-bit counter times vertical periods and its upper 9 bits are latched.
// [RL9] the vertical latch loads at every pulse of the selected vertical source.
// [RL10] each counter has a status bit that shows an overflow in its interval.
// [RL11] a change event fires when a latched count changes or its counter overflowed.
// [RL12] an overflow bit clears by itself once an interval ends without overflow.
// [RL13] vertical present sets above 40 Hz and clears below 10 Hz.
// [RL14] counters restart at zero each interval and freeze once they saturate.
module sfm_meter
   import sfm_pkg::*;
#(
   parameter int unsigned H_LINES       = H_LINES_DEF,
   parameter int unsigned VPRES_SET_CYC = VPRES_SET_DEF,
   parameter int unsigned VPRES_CLR_CYC = VPRES_CLR_DEF
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        hsync_in,
   input  wire logic        vsync_in,
   output logic             vert_blank_output,
   output logic             separated_vert_pulse,
   output logic             composite_vert_present_flag,
   output logic             horiz_freq_change_irq,
   output logic             vert_freq_change_irq
);

   if (H_LINES < 2 || (H_LINES & (H_LINES - 1)) != 0 || H_LINES > 256)
   begin : g_bad_lines
      $error("H_LINES must be a power of two from 2 to 256");
   end
   if (VPRES_SET_CYC >= VPRES_CLR_CYC || VPRES_CLR_CYC >= (1 << PRES_W))
   begin : g_bad_pres
      $error("presence thresholds out of range");
   end

   localparam int unsigned LINE_W = $clog2(H_LINES);

   logic [CTRL_W-1:0]  ctrl_ff, nxt_ctrl;
   logic [1:0]         raw_sync, lvl, rise;
   logic               hs_lvl, hs_rise, v_lvl, v_evt;

   // polarity fix-up ahead of the noise filters, one filter per sync line
   assign raw_sync = {vsync_in ^ ctrl_ff[CTRL_VINV_BIT], hsync_in ^ ctrl_ff[CTRL_HINV_BIT]};

   for (genvar gi = 0; gi < 2; gi++)
   begin : g_filt
      sfm_sync_filter u_filt
      (
         .hclk    (hclk),
         .hresetn (hresetn),
         .din     (raw_sync[gi]),
         .level   (lvl[gi]),
         .rise    (rise[gi])
      );
   end
   assign hs_lvl  = lvl[0];
   assign hs_rise = rise[0];

   // composite separation: an active horizontal pulse that outlasts the separation time
   sfm_sep_type        sep_ff, nxt_sep;
   logic [SEP_W-1:0]   width_ff, nxt_width;
   logic               cv_fire;

   always_comb
   begin
      nxt_sep   = sep_ff;
      nxt_width = width_ff;
      cv_fire   = 1'b0;
      unique case (sep_ff)
         SEP_IDLE:
         begin
            nxt_width = '0;
            if (hs_lvl)
            begin
               nxt_sep   = SEP_WIDTH;
               nxt_width = SEP_W'(1);
            end
         end
         SEP_WIDTH:
         begin
            if (!hs_lvl)
               nxt_sep = SEP_IDLE; // ordinary line sync
            else if (width_ff == SEP_W'(SEP_CYC - 1))
            begin
               nxt_sep = SEP_VERT; // RL2 RL4
               cv_fire = 1'b1;
            end
            else
               nxt_width = width_ff + SEP_W'(1);
         end
         SEP_VERT:
         begin
            if (!hs_lvl)
               nxt_sep = SEP_IDLE;
         end
         default:
            nxt_sep = SEP_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sep_ff   <= SEP_IDLE;
         width_ff <= '0;
      end
      else
      begin
         sep_ff   <= nxt_sep;
         width_ff <= nxt_width;
      end
   end

   // vertical source select; the separated pulse lags by the separation time
   assign v_lvl = ctrl_ff[CTRL_VSRC_BIT] ? (sep_ff == SEP_VERT) : lvl[1]; // RL3
   assign v_evt = ctrl_ff[CTRL_VSRC_BIT] ? cv_fire : rise[1];            // RL3 RL9

   // presence: slot 0 tracks the separated pulse, slot 1 the selected vertical source
   logic [1:0]         pres_evt;
   logic [PRES_W-1:0]  gap_ff [2];
   logic [PRES_W-1:0]  nxt_gap [2];
   logic               pres_ff [2];
   logic               nxt_pres [2];

   assign pres_evt = {v_evt, cv_fire};

   for (genvar gi = 0; gi < 2; gi++)
   begin : g_pres
      always_comb
      begin
         nxt_gap[gi]  = gap_ff[gi];
         nxt_pres[gi] = pres_ff[gi];
         if (pres_evt[gi])
         begin
            nxt_gap[gi] = '0;
            if (gi == 0 || gap_ff[gi] < PRES_W'(VPRES_SET_CYC))
               nxt_pres[gi] = 1'b1; // RL2 RL13
         end
         else if (gap_ff[gi] >= PRES_W'(VPRES_CLR_CYC - 1))
            nxt_pres[gi] = 1'b0; // RL13
         else
            nxt_gap[gi] = gap_ff[gi] + PRES_W'(1);
      end

      // gap starts full so no source counts as present after reset
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            gap_ff[gi]  <= PRES_W'(VPRES_CLR_CYC - 1);
            pres_ff[gi] <= 1'b0;
         end
         else
         begin
            gap_ff[gi]  <= nxt_gap[gi];
            pres_ff[gi] <= nxt_pres[gi];
         end
      end
   end

   // horizontal measurement over H_LINES periods, counting on every second edge
   logic [H_CNT_W-1:0] hcnt_ff, nxt_hcnt;
   logic [LINE_W-1:0]  line_ff, nxt_line;
   logic [H_LAT_W-1:0] hres_ff, nxt_hres, hlat_ff, nxt_hlat, hload_val;
   logic               htick_ff, nxt_htick, harm_ff, nxt_harm, hres_ovf_ff, nxt_hres_ovf;
   logic               h_ovf_ff, nxt_h_ovf, hirq_ff, nxt_hirq;
   logic               hsat, h_done, h_start, hload, hload_ovf;

   assign hsat    = &hcnt_ff;
   assign h_start = hs_rise && !harm_ff;
   assign h_done  = hs_rise && harm_ff && (line_ff == LINE_W'(H_LINES - 1));
   assign hload     = pres_ff[1] ? v_evt : h_done;                          // RL7
   assign hload_val = pres_ff[1] ? hres_ff : hcnt_ff[H_CNT_W-1 -: H_LAT_W]; // RL6
   assign hload_ovf = pres_ff[1] ? hres_ovf_ff : hsat;

   always_comb
   begin
      nxt_harm     = harm_ff | hs_rise;
      nxt_line     = hs_rise ? line_ff + LINE_W'(1) : line_ff;
      nxt_htick    = ~htick_ff;
      nxt_hcnt     = hcnt_ff;
      nxt_hres     = hres_ff;
      nxt_hres_ovf = hres_ovf_ff;
      nxt_h_ovf    = h_ovf_ff | hsat;                      // RL10
      if (h_start || h_done)
      begin
         nxt_hcnt  = '0;                                  // RL14
         nxt_htick = 1'b1;                                // first tick counts: 2n clocks give n
         nxt_line  = '0;
         if (h_done)
         begin
            nxt_hres     = hcnt_ff[H_CNT_W-1 -: H_LAT_W]; // RL5 RL6
            nxt_hres_ovf = hsat;
            nxt_h_ovf    = hsat;                          // RL12
         end
      end
      else if (htick_ff && !hsat)
         nxt_hcnt = hcnt_ff + H_CNT_W'(1);                // RL5 RL14
      nxt_hlat = hload ? hload_val : hlat_ff;
      nxt_hirq = hload && (hload_val != hlat_ff || hload_ovf); // RL11
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hcnt_ff     <= '0;
         line_ff     <= '0;
         htick_ff    <= 1'b0;
         harm_ff     <= 1'b0;
         hres_ff     <= '0;
         hres_ovf_ff <= 1'b0;
         h_ovf_ff    <= 1'b0;
         hlat_ff     <= '0;
         hirq_ff     <= 1'b0;
      end
      else
      begin
         hcnt_ff     <= nxt_hcnt;
         line_ff     <= nxt_line;
         htick_ff    <= nxt_htick;
         harm_ff     <= nxt_harm;
         hres_ff     <= nxt_hres;
         hres_ovf_ff <= nxt_hres_ovf;
         h_ovf_ff    <= nxt_h_ovf;
         hlat_ff     <= nxt_hlat;
         hirq_ff     <= nxt_hirq;
      end
   end

   // vertical measurement in ticks of V_TICK_CYC clocks between source pulses
   logic [V_CNT_W-1:0]  vcnt_ff, nxt_vcnt;
   logic [V_TICK_W-1:0] vtick_ff, nxt_vtick;
   logic [V_LAT_W-1:0]  vlat_ff, nxt_vlat;
   logic                v_ovf_ff, nxt_v_ovf, virq_ff, nxt_virq, vert_blank_output_ff, vsat;

   assign vsat = &vcnt_ff;

   always_comb
   begin
      nxt_vcnt  = vcnt_ff;
      nxt_vtick = vtick_ff + V_TICK_W'(1);
      nxt_vlat  = vlat_ff;
      nxt_v_ovf = v_ovf_ff | vsat;                          // RL10
      nxt_virq  = 1'b0;
      if (v_evt)
      begin
         nxt_vlat  = vcnt_ff[V_CNT_W-1 -: V_LAT_W];         // RL8 RL9
         nxt_v_ovf = vsat;                                  // RL12
         nxt_virq  = (nxt_vlat != vlat_ff) || vsat;         // RL11
         nxt_vcnt  = '0;                                    // RL14
         nxt_vtick = '0;
      end
      else if (vtick_ff == V_TICK_W'(V_TICK_CYC - 1) && !vsat)
         nxt_vcnt = vcnt_ff + V_CNT_W'(1);                  // RL8 RL14
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         vcnt_ff   <= '0;
         vtick_ff  <= '0;
         vlat_ff   <= '0;
         v_ovf_ff  <= 1'b0;
         virq_ff   <= 1'b0;
         vert_blank_output_ff <= 1'b0;
      end
      else
      begin
         vcnt_ff   <= nxt_vcnt;
         vtick_ff  <= nxt_vtick;
         vlat_ff   <= nxt_vlat;
         v_ovf_ff  <= nxt_v_ovf;
         virq_ff   <= nxt_virq;
         vert_blank_output_ff <= v_lvl; // RL3
      end
   end

   assign vert_blank_output           = vert_blank_output_ff;
   assign separated_vert_pulse        = (sep_ff == SEP_VERT);
   assign composite_vert_present_flag = pres_ff[0];
   assign horiz_freq_change_irq       = hirq_ff;
   assign vert_freq_change_irq        = virq_ff;

   // ahb-lite slave: zero wait states, read data registered in the address phase
   logic             ap_take, wr_pend_ff;
   logic [DEC_W-1:0] waddr_ff;
   logic [31:0]      rdata_ff, nxt_rdata;
   logic [7:0]       sel_ofs;

   assign ap_take = hsel && htrans[1] && hready;
   assign sel_ofs = haddr[DEC_W-1:0];

   // a write lands in its data phase; a read of OFS_CTRL in the same cycle sees the new value, the status source bit still the old one
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      if (wr_pend_ff && waddr_ff == OFS_CTRL)
         nxt_ctrl = hwdata[CTRL_W-1:0];
      nxt_rdata = rdata_ff;
      if (ap_take && !hwrite)
      begin
         unique case (sel_ofs)
            OFS_STATUS:  nxt_rdata = {29'h0, ctrl_ff[CTRL_VSRC_BIT], pres_ff[1], pres_ff[0]};
            OFS_HCNT_HI: nxt_rdata = {24'h0, h_ovf_ff, 4'h0, hlat_ff[10:8]};
            OFS_HCNT_LO: nxt_rdata = {24'h0, hlat_ff[7:0]};
            OFS_VCNT_HI: nxt_rdata = {24'h0, v_ovf_ff, 6'h0, vlat_ff[8]};
            OFS_VCNT_LO: nxt_rdata = {24'h0, vlat_ff[7:0]};
            OFS_CTRL:    nxt_rdata = {29'h0, nxt_ctrl};
            default:     nxt_rdata = 32'h0; // unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_ff    <= CTRL_RESET;
         wr_pend_ff <= 1'b0;
         waddr_ff   <= '0;
         rdata_ff   <= 32'h0;
      end
      else
      begin
         ctrl_ff    <= nxt_ctrl;
         wr_pend_ff <= ap_take && hwrite;
         waddr_ff   <= sel_ofs;
         rdata_ff   <= nxt_rdata;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_ff;

   // helper: length of the current active horizontal level, for the lag check
   logic [SEP_W-1:0] act_cnt_ff;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         act_cnt_ff <= '0;
      else
         act_cnt_ff <= !hs_lvl ? '0 : ((&act_cnt_ff) ? act_cnt_ff : act_cnt_ff + SEP_W'(1));
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_sep_present: assert property (cv_fire |=> composite_vert_present_flag) // RL2
      else $error("separated pulse did not set present flag");
   a_sep_lag_time: assert property ($rose(separated_vert_pulse) |-> act_cnt_ff == SEP_CYC) // RL4
      else $error("separated pulse lag wrong");
   a_vert_blank_output_source: assert property (##1 vert_blank_output == $past(v_lvl)) // RL3
      else $error("blank output not from selected source");
   a_hcnt_restart: assert property ((h_done || h_start) |=> hcnt_ff == '0 ##1 hcnt_ff <= 1) // RL14
      else $error("horizontal counter did not restart");
   a_hlatch_free: assert property ((h_done && !pres_ff[1]) |=> hlat_ff == $past(hcnt_ff[14:4])) // RL6
      else $error("horizontal latch wrong without vertical");
   a_hlatch_hold: assert property ((pres_ff[1] && !v_evt) |=> $stable(hlat_ff)) // RL7
      else $error("horizontal latch moved between vertical pulses");
   a_vlatch_load: assert property (v_evt |=> vlat_ff == $past(vcnt_ff[13:5])) // RL8
      else $error("vertical latch wrong");
   a_hovf_flag: assert property ((hsat && !h_done && !h_start) |=> h_ovf_ff && hsat) // RL10
      else $error("overflow not flagged or counter moved");
   a_hovf_clear: assert property ((h_done && !hsat) |=> !h_ovf_ff) // RL12
      else $error("overflow bit not cleared");
   a_virq_cause: assert property (vert_freq_change_irq |-> $past(v_evt)
                                  && ($past(vsat) || vlat_ff != $past(vlat_ff))) // RL11
      else $error("vertical change event without cause");
   a_vpres_drop: assert property ((gap_ff[1] >= PRES_W'(VPRES_CLR_CYC - 1) && !v_evt)
                                  |=> !pres_ff[1]) // RL13
      else $error("vertical present not cleared");

   c_sep_found: cover property (cv_fire);
   c_h_interval: cover property (h_done && !hsat);
   c_h_irq: cover property (horiz_freq_change_irq);
   c_v_irq: cover property (v_evt ##1 vert_freq_change_irq);

endmodule

// File: sfm_pkg.sv
package sfm_pkg;

   // clock and timing figures
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned SEP_TIME_NS     = 10000;   // least width of a vertical pulse
   localparam int unsigned SEP_CYC         = (SEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SEP_W           = 9;
   localparam int unsigned VPRES_SET_US    = 25000;   // 40 Hz
   localparam int unsigned VPRES_CLR_US    = 100000;  // 10 Hz
   localparam int unsigned VPRES_SET_DEF   = (VPRES_SET_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned VPRES_CLR_DEF   = (VPRES_CLR_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned PRES_W          = 21;

   // measurement counters
   localparam int unsigned H_CNT_W         = 15;
   localparam int unsigned H_LAT_W         = 11;
   localparam int unsigned H_LINES_DEF     = 64;
   localparam int unsigned H_TICK_CYC      = 2;
   localparam int unsigned V_CNT_W         = 14;
   localparam int unsigned V_LAT_W         = 9;
   localparam int unsigned V_UNIT_CYC      = 512;
   localparam int unsigned V_TICK_CYC      = V_UNIT_CYC >> (V_CNT_W - V_LAT_W);
   localparam int unsigned V_TICK_W        = 4;

   // register byte offsets (low address bits decoded)
   localparam int unsigned DEC_W           = 8;
   localparam logic [7:0]  OFS_STATUS      = 8'h00;
   localparam logic [7:0]  OFS_HCNT_HI     = 8'h04;
   localparam logic [7:0]  OFS_HCNT_LO     = 8'h08;
   localparam logic [7:0]  OFS_VCNT_HI     = 8'h0c;
   localparam logic [7:0]  OFS_VCNT_LO     = 8'h10;
   localparam logic [7:0]  OFS_CTRL        = 8'h14;

   // control fields
   localparam int unsigned CTRL_W          = 3;
   localparam int unsigned CTRL_VSRC_BIT   = 0;
   localparam int unsigned CTRL_HINV_BIT   = 1;
   localparam int unsigned CTRL_VINV_BIT   = 2;
   localparam logic [2:0]  CTRL_RESET      = 3'h0;
   localparam int unsigned OVF_BIT         = 7;

   typedef enum logic [2:0]
   {
      SEP_IDLE  = 3'b001,
      SEP_WIDTH = 3'b010,
      SEP_VERT  = 3'b100
   } sfm_sep_type;

endpackage

// File: sfm_sync_filter.sv
`timescale 1ns/10ps
module sfm_sync_filter
   import sfm_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic din,
   output logic      level,
   output logic      rise
);

   logic samp_ff;
   logic level_ff;
   logic rise_ff;
   logic nxt_level;
   logic nxt_rise;

   // a new level is taken only when seen on two edges in a row
   always_comb
   begin
      nxt_level = (din == samp_ff) ? din : level_ff; // RL1
      nxt_rise  = nxt_level & ~level_ff;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         samp_ff  <= 1'b0;
         level_ff <= 1'b0;
         rise_ff  <= 1'b0;
      end
      else
      begin
         samp_ff  <= din;
         level_ff <= nxt_level;
         rise_ff  <= nxt_rise;
      end
   end

   assign level = level_ff;
   assign rise  = rise_ff;

   a_filter_glitch: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      $changed(level_ff) |-> ($past(din) == level_ff) && ($past(din, 2) == level_ff))
      else $error("filtered level moved on a single-cycle input");

endmodule

// File: sfm_sync_source.sv
`timescale 1ns/10ps
// behavioural video source: line pulses, vertical pulses or broad composite pulses
module sfm_sync_source
(
   input  wire logic        hclk,
   input  wire logic        h_en,
   input  wire logic        v_en,
   input  wire logic        comp_en,
   input  wire logic        glitch_en,
   input  wire logic [31:0] h_period,
   input  wire logic [31:0] h_width,
   input  wire logic [31:0] v_period,
   input  wire logic [31:0] v_width,
   output logic             hsync_in,
   output logic             vsync_in
);
   // time base starts at zero; the lines are unknown only until the first edge, inside reset
   logic [31:0] t_ff = 32'h0;

   // one free time base, so every period is exact and phases never drift
   always @(posedge hclk)
   begin
      t_ff     <= t_ff + 32'h1;
      hsync_in <= (h_en && (t_ff % h_period) < h_width)
                  || (glitch_en && (t_ff % h_period) == h_period / 2)
                  || (comp_en && (t_ff % v_period) < v_width);
      vsync_in <= v_en && (t_ff % v_period) < v_width;
   end
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top
   import sfm_pkg::*;
;
   localparam int unsigned HL  = 16;
   localparam int unsigned SET = 8000;
   localparam int unsigned CLR = 9000;
   localparam int unsigned HP  = 104;
   localparam int unsigned VP1 = 5376;
   localparam int unsigned VP2 = 7424;

   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hsync_in, vsync_in, vert_blank_output, separated_vert_pulse;
   logic        composite_vert_present_flag, horiz_freq_change_irq, vert_freq_change_irq;
   logic        h_en, v_en, comp_en, glitch_en;
   logic [31:0] v_period, v_width;
   int          fail_count, n_compared;
   int          hirq_n = 0;
   int          virq_n = 0;

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   sfm_meter #(.H_LINES(HL), .VPRES_SET_CYC(SET), .VPRES_CLR_CYC(CLR)) uut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .hsync_in(hsync_in), .vsync_in(vsync_in),
      .vert_blank_output(vert_blank_output), .separated_vert_pulse(separated_vert_pulse),
      .composite_vert_present_flag(composite_vert_present_flag),
      .horiz_freq_change_irq(horiz_freq_change_irq),
      .vert_freq_change_irq(vert_freq_change_irq));

   sfm_sync_source src (.hclk(hclk), .h_en(h_en), .v_en(v_en), .comp_en(comp_en),
      .glitch_en(glitch_en), .h_period(HP), .h_width(32'ha), .v_period(v_period),
      .v_width(v_width), .hsync_in(hsync_in), .vsync_in(vsync_in));

   // clock and change-event counters
   initial hclk = 1'b0;
   always #(CLK_PERIOD_NS / 2) hclk = ~hclk;
   always @(posedge hclk)
   begin
      if (horiz_freq_change_irq === 1'b1) hirq_n <= hirq_n + 1;
      if (vert_freq_change_irq === 1'b1) virq_n <= virq_n + 1;
   end

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // one single transfer; every wait on ready is cut short only by the watchdog
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp, what);
      chk(hresp, 32'h0, "okay response");
   endtask

   // sel: 0 vertical input, 1 separated pulse, 2 horizontal input
   task automatic wait_rise(input int sel, input int n);
      logic prev;
      logic cur;
      repeat (n)
      begin
         cur = 1'b1;
         do
         begin
            prev = cur;
            @(posedge hclk);
            #1;
            cur = (sel == 0) ? vsync_in : (sel == 1) ? separated_vert_pulse : hsync_in;
         end
         while (!(prev === 1'b0 && cur === 1'b1));
      end
   endtask

   task automatic t_regs();
      rchk(OFS_STATUS, 32'h0, "status reset");
      rchk(OFS_CTRL, {29'h0, CTRL_RESET}, "ctrl reset");
      rchk(OFS_HCNT_LO, 32'h0, "hcnt reset");
      rchk(OFS_VCNT_HI, 32'h0, "vcnt reset");
      wr(OFS_CTRL, 32'h7);
      rchk(OFS_CTRL, 32'h7, "ctrl readback");
      wr(OFS_CTRL, 32'h0);
      wr(8'h18, 32'hff);
      rchk(8'h18, 32'h0, "unmapped read");
      $display("test regs done");
   endtask

   // line pulses with one-cycle glitches mid-line; a counted glitch halves the result
   task automatic t_horiz();
      logic [31:0] exp;
      int          n0;
      exp       = (HL * HP / H_TICK_CYC) >> (H_CNT_W - H_LAT_W);
      glitch_en <= 1'b1;
      h_en      <= 1'b1;
      cycles(3 * HL * HP);
      rchk(OFS_HCNT_LO, exp & 32'hff, "hcnt low");
      rchk(OFS_HCNT_HI, exp >> 8, "hcnt high");
      chk(32'(hirq_n != 0), 32'h1, "h change event");
      n0 = hirq_n;
      cycles(2 * HL * HP);
      rchk(OFS_HCNT_LO, exp & 32'hff, "hcnt refreshed");
      chk(hirq_n - n0, 32'h0, "h steady no event");
      h_en      <= 1'b0;
      glitch_en <= 1'b0;
      $display("test horiz done");
   endtask

   task automatic t_vert();
      int n0;
      v_period <= VP1;
      v_width  <= 32'h14;
      v_en     <= 1'b1;
      wait_rise(0, 4);
      rchk(OFS_VCNT_LO, VP1 / V_UNIT_CYC, "vcnt low");
      rchk(OFS_VCNT_HI, 32'h0, "vcnt high");
      rchk(OFS_STATUS, 32'h2, "vert present");
      chk(32'(virq_n != 0), 32'h1, "v change event");
      n0 = virq_n;
      wait_rise(0, 1);
      cycles(10);
      chk(vert_blank_output, 32'h1, "blank follows vsync");
      chk(virq_n - n0, 32'h0, "v steady no event");
      v_en <= 1'b0;
      cycles(CLR + 100);
      rchk(OFS_STATUS, 32'h0, "vert absent");
      $display("test vert done");
   endtask

   // broad pulses on the horizontal line only, separated pulse chosen as source
   task automatic t_comp();
      int          n;
      logic [31:0] q;
      wr(OFS_CTRL, 32'h1);
      chk(composite_vert_present_flag, 32'h0, "flag clear before");
      v_period <= VP2;
      v_width  <= 32'h12c;
      comp_en  <= 1'b1;
      wait_rise(2, 1);
      n = 0;
      while (separated_vert_pulse !== 1'b1 && n < 1000)
      begin
         cycles(1);
         n++;
      end
      chk(n, SEP_CYC + 2, "separation lag");
      chk(composite_vert_present_flag, 32'h1, "flag with pulse");
      cycles(1);
      chk(composite_vert_present_flag, 32'h1, "flag set");
      cycles(20);
      chk({vsync_in, vert_blank_output}, 32'h1, "blank from separated");
      wait_rise(1, 3);
      cycles(10);
      rchk(OFS_VCNT_LO, VP2 / V_UNIT_CYC, "vcnt separated");
      bus(1'b0, OFS_STATUS, 32'h0, q);
      chk(q & 32'h5, 32'h5, "composite status");
      comp_en <= 1'b0;
      $display("test comp done");
   endtask

   // reset for five cycles, then the scenarios in turn
   initial
   begin
      {hsel, hwrite, hresetn, h_en, v_en, comp_en, glitch_en} = 7'h0;
      haddr      = 32'h0;
      hwdata     = 32'h0;
      htrans     = 2'b00;
      hsize      = 3'b010;
      v_period   = VP1;
      v_width    = 32'h14;
      fail_count = 0;
      n_compared = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_horiz();
      t_vert();
      t_comp();
      conclude();
   end

   // a hang costs more than the whole planned run
   initial
   begin
      #(100000 * CLK_PERIOD_NS);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      conclude();
   end
endmodule
